// >>> verilog/jla_consts.svh
// Purpose: Constants of the LMFC and SYSREF alignment block
// Assumes: Delays are in device clock periods, tenths where fractional
// Notes:   Definitions only
`ifndef JLA_CONSTS_SVH
`define JLA_CONSTS_SVH

// ****************************************************************
// SYSREF and LMFC timing
// ****************************************************************
`define JLA_SREF_LMFC_CYC    40
`define JLA_SYSREF_MIN_CYC   8

// ****************************************************************
// LMFC to multiframe functional delays, tenths of a device period
// ****************************************************************
`define JLA_DTX_BYP_TENTHS   527
`define JLA_DTX_D0P0_TENTHS  607
`define JLA_DTX_D0P1_TENTHS  515
`define JLA_DTX_D1P0_TENTHS  527
`define JLA_DTX_D1P1_TENTHS  439
`define JLA_TENTHS_PER_CYC   10
`define JLA_PROP_MAX_CYC     3

// ****************************************************************
// SYNC and lane alignment
// ****************************************************************
`define JLA_SYNC_SETUP_CYC   40
`define JLA_SYNC_MIN_FRAMES  4
`define JLA_ILA_MF           4

// ****************************************************************
// Device clocks per frame octet, per rate setting
// ****************************************************************
`define JLA_MULT_D0P0        10
`define JLA_MULT_D0P1        8
`define JLA_MULT_D1P0        5
`define JLA_MULT_D1P1        4
`define JLA_DECIM_BYPASS     6'h01

`endif

// >>> verilog/jla_pkg.sv
// Purpose: Types of the LMFC and SYSREF alignment block
// Assumes: Nothing
// Notes:   Constants live in jla_consts.svh
package jla_pkg;

   // Link states seen on the transmitted lanes
   typedef enum logic [1:0] {
      JLA_ST_CGS,
      JLA_ST_WAIT_MF,
      JLA_ST_ILA,
      JLA_ST_DATA
   } jla_link_state_type;

endpackage

// >>> verilog/jla_delay_line.sv
// Purpose: Pulse delay line with a selectable tap
// Assumes: tap_i is at least 1 and at most DEPTH
// Notes:   Output is a mux of flops, delay equals tap_i edges
`timescale 1ns/1ns
module jla_delay_line #(
   parameter int DEPTH = 64
) (
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       pulse_i,
   input  wire logic [6:0] tap_i,
   output wire logic       pulse_o
);

   logic [DEPTH-1:0] stage;

   // ****************************************************************
   // Shift stages
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_stage
         // One flop per stage
         always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               stage[g] <= 1'b0;
            end else begin
               stage[g] <= (g == 0) ? pulse_i : stage[(g == 0) ? 0 : g-1];
            end
         end
      end
   endgenerate

   // Tap select
   assign pulse_o = stage[tap_i - 7'h01];

endmodule // jla_delay_line

// >>> verilog/jla_align.sv
// Purpose: LMFC alignment to SYSREF, multiframe placement, SYNC handling
// Assumes: All inputs synchronous to mclk_i, the device clock
// Notes:   Rate settings must be held steady while the link runs
`timescale 1ns/1ns
`include "jla_consts.svh"

module jla_align
   import jla_pkg::*;
#(
   parameter int K_FRAMES  = 32, // Frames per multiframe
   parameter int F_OCTETS  = 1,  // Octets per frame
   parameter int PROP_CYC  = 0,  // Extra propagation cycles, 0 to 3
   parameter int CW        = 12  // LMFC counter width
) (
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       sysref_i,
   input  wire logic       sync_n_i,
   input  wire logic       double_rate_i,
   input  wire logic       five_four_ratio_sel_i,
   input  wire logic [5:0] decim_i,
   output logic            lmfc_o,
   output logic            frame_o,
   output logic            mf_start_o,
   output logic            cgs_o,
   output logic            ila_o,
   output logic            data_o,
   output logic            resync_o,
   output logic            sync_aligned_o
);

   // ****************************************************************
   // Mode decode
   // ****************************************************************

   // Device clocks per octet for a rate setting
   function automatic logic [3:0] jla_mult(input logic ddr, input logic p54);
      logic [3:0] m;
      m = 4'h0;
      case ({ddr, p54})
         2'b00:   m = 4'(`JLA_MULT_D0P0);
         2'b01:   m = 4'(`JLA_MULT_D0P1);
         2'b10:   m = 4'(`JLA_MULT_D1P0);
         default: m = 4'(`JLA_MULT_D1P1);
      endcase
      return m;
   endfunction

   // Whole cycles of a fractional delay, rounded up
   function automatic logic [6:0] jla_ceil(input int tenths);
      return 7'((tenths + `JLA_TENTHS_PER_CYC - 1) / `JLA_TENTHS_PER_CYC);
   endfunction

   localparam logic [6:0] DTX_BYP  = jla_ceil(`JLA_DTX_BYP_TENTHS);
   localparam logic [6:0] DTX_D0P0 = jla_ceil(`JLA_DTX_D0P0_TENTHS);
   localparam logic [6:0] DTX_D0P1 = jla_ceil(`JLA_DTX_D0P1_TENTHS);
   localparam logic [6:0] DTX_D1P0 = jla_ceil(`JLA_DTX_D1P0_TENTHS);
   localparam logic [6:0] DTX_D1P1 = jla_ceil(`JLA_DTX_D1P1_TENTHS);
   localparam logic [6:0] PROP     = 7'(PROP_CYC);
   localparam int         DL_DEPTH = 64 + `JLA_PROP_MAX_CYC;

   wire             bypass;
   wire [3:0]       mult;
   wire [CW-1:0]    frame_len;
   wire [CW-1:0]    mf_len;
   wire [6:0]       dtx_mode;
   wire [6:0]       dtx_tap;

   assign bypass    = (decim_i == `JLA_DECIM_BYPASS);
   assign mult      = jla_mult(double_rate_i, five_four_ratio_sel_i);
   assign frame_len = CW'(F_OCTETS) * CW'(mult);
   assign mf_len    = CW'(K_FRAMES) * frame_len;

   // Functional LMFC to multiframe delay per mode
   assign dtx_mode  = bypass                                     ? DTX_BYP  :
                      (!double_rate_i && !five_four_ratio_sel_i) ? DTX_D0P0 :
                      (!double_rate_i &&  five_four_ratio_sel_i) ? DTX_D0P1 :
                      (!five_four_ratio_sel_i)                   ? DTX_D1P0 :
                                                                   DTX_D1P1;
   // Output flop adds one edge behind the delay line
   assign dtx_tap   = dtx_mode + PROP - 7'h01;

   // ****************************************************************
   // SYSREF capture and LMFC
   // ****************************************************************
   logic            sysref_q;
   logic            sref_pend;
   logic [5:0]      sref_cnt;
   logic [CW-1:0]   lmfc_cnt;
   logic [CW-1:0]   frame_cnt;
   wire             sref_rise;
   wire             realign;
   wire             lmfc_wrap;
   wire             frame_wrap;

   // Edge on sampled levels; a pulse shorter than one device clock may be missed
   assign sref_rise  = sysref_i & ~sysref_q;
   assign realign    = sref_pend && (sref_cnt == 6'h00);
   assign lmfc_wrap  = (lmfc_cnt == mf_len - CW'(1));
   assign frame_wrap = (frame_cnt == frame_len - CW'(1));

   // SYSREF sample and countdown to the boundary
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sysref_q  <= 1'b0;
         sref_pend <= 1'b0;
         sref_cnt  <= 6'h00;
      end else begin
         sysref_q <= sysref_i;
         if (sref_rise) begin
            sref_pend <= 1'b1;
            sref_cnt  <= 6'(`JLA_SREF_LMFC_CYC - 1);
         end else if (realign) begin
            sref_pend <= 1'b0;
         end else if (sref_pend) begin
            sref_cnt <= sref_cnt - 6'h01;
         end
      end
   end

   // Free running LMFC and frame counters, restarted on realignment
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lmfc_cnt  <= '0;
         frame_cnt <= '0;
         lmfc_o    <= 1'b0;
         frame_o   <= 1'b0;
      end else begin
         lmfc_cnt  <= (realign || lmfc_wrap) ? '0 : lmfc_cnt + CW'(1);
         frame_cnt <= (realign || lmfc_wrap || frame_wrap) ? '0 : frame_cnt + CW'(1);
         lmfc_o    <= realign || lmfc_wrap;
         frame_o   <= realign || lmfc_wrap || frame_wrap;
      end
   end

   // ****************************************************************
   // Multiframe start in the transmitted data
   // ****************************************************************
   wire             mf_tap;

   jla_delay_line #(
      .DEPTH   (DL_DEPTH)
   ) u_dtx (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .pulse_i (lmfc_o),
      .tap_i   (dtx_tap),
      .pulse_o (mf_tap)
   );

   // Registered multiframe start
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mf_start_o <= 1'b0;
      end else begin
         mf_start_o <= mf_tap;
      end
   end

   // ****************************************************************
   // SYNC request tracking
   // ****************************************************************
   logic            sync_q;
   logic [2:0]      low_frames;
   wire             sync_rise;
   wire             sync_long;
   wire [CW-1:0]    to_boundary;

   assign sync_rise   = sync_n_i & ~sync_q;
   assign sync_long   = (low_frames >= 3'(`JLA_SYNC_MIN_FRAMES));
   assign to_boundary = mf_len - lmfc_cnt;

   // Frame clocks seen with SYNC low, saturating
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_q     <= 1'b1;
         low_frames <= 3'h0;
      end else begin
         sync_q <= sync_n_i;
         if (sync_n_i) begin
            low_frames <= 3'h0;
         end else if (frame_o && !sync_long) begin
            low_frames <= low_frames + 3'h1;
         end
      end
   end

   // Alignment flag; a late release still runs the link
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_aligned_o <= 1'b0;
      end else if (sync_rise && sync_long) begin
         sync_aligned_o <= (to_boundary >= CW'(`JLA_SYNC_SETUP_CYC));
      end
   end

   // ****************************************************************
   // Link state machine
   // ****************************************************************
   jla_link_state_type state;
   jla_link_state_type next_state;
   logic [1:0]         ila_cnt;
   logic [1:0]         next_ila_cnt;

   // Next state and alignment multiframe count
   always_comb begin
      next_state   = state;
      next_ila_cnt = ila_cnt;
      case (state)
         JLA_ST_CGS: begin
            if (sync_rise && sync_long) begin
               next_state = JLA_ST_WAIT_MF;
            end
         end
         JLA_ST_WAIT_MF: begin
            if (mf_start_o) begin
               next_state   = JLA_ST_ILA;
               next_ila_cnt = 2'h0;
            end
         end
         JLA_ST_ILA: begin
            if (mf_start_o) begin
               if (ila_cnt == 2'(`JLA_ILA_MF - 1)) begin
                  next_state = JLA_ST_DATA;
               end else begin
                  next_ila_cnt = ila_cnt + 2'h1;
               end
            end
         end
         JLA_ST_DATA: begin
            if (sync_long) begin
               next_state = JLA_ST_CGS;
            end
         end
         default: begin
            next_state = JLA_ST_CGS;
         end
      endcase
      if (state != JLA_ST_CGS && state != JLA_ST_DATA && sync_long) begin
         next_state = JLA_ST_CGS;
      end
   end

   // State and registered lane flags
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state    <= JLA_ST_CGS;
         ila_cnt  <= 2'h0;
         cgs_o    <= 1'b1;
         ila_o    <= 1'b0;
         data_o   <= 1'b0;
         resync_o <= 1'b0;
      end else begin
         state    <= next_state;
         ila_cnt  <= next_ila_cnt;
         cgs_o    <= (next_state == JLA_ST_CGS) || (next_state == JLA_ST_WAIT_MF);
         ila_o    <= (next_state == JLA_ST_ILA);
         data_o   <= (next_state == JLA_ST_DATA);
         resync_o <= (next_state == JLA_ST_CGS) && (state != JLA_ST_CGS);
      end
   end

endmodule // jla_align

// >>> sim/jla_align_asserts.sv
// Purpose: Concurrent checks on the ports of the alignment block
// Assumes: One clock domain, reset active low
// Notes:   Bound into every jla_align instance
`timescale 1ns/1ns
`include "jla_consts.svh"
module jla_align_asserts #(
   parameter int PROP_CYC = 0
) (
   input wire logic       mclk_i,
   input wire logic       rst_n_i,
   input wire logic       sysref_i,
   input wire logic       sync_n_i,
   input wire logic       double_rate_i,
   input wire logic       five_four_ratio_sel_i,
   input wire logic [5:0] decim_i,
   input wire logic       lmfc_o,
   input wire logic       frame_o,
   input wire logic       mf_start_o,
   input wire logic       cgs_o,
   input wire logic       ila_o,
   input wire logic       data_o,
   input wire logic       resync_o,
   input wire logic       sync_aligned_o
);
   // ************************************************
   // Helper logic
   // ************************************************
   logic [63:0] hist;
   logic [2:0]  icnt;
   logic [6:0]  dly;

   // Rounded-up multiframe delay for the current rate setting
   assign dly = (decim_i == `JLA_DECIM_BYPASS) ? 7'h35 :
                double_rate_i ? (five_four_ratio_sel_i ? 7'h2c : 7'h35) :
                (five_four_ratio_sel_i ? 7'h34 : 7'h3d);

   // History of boundary pulses and count of multiframes in alignment
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hist <= '0;
         icnt <= 3'h0;
      end else begin
         hist <= {hist[62:0], lmfc_o};
         icnt <= !ila_o ? 3'h0 : icnt + {2'h0, mf_start_o};
      end
   end

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   // Boundary lands on the 40th edge; the registered pulse is sampled one edge later
   a_sref_lmfc_delay: assert property ($rose(sysref_i) |-> ##41 lmfc_o)
      else $error("lmfc late or missing after sysref");
   a_mf_after_lmfc: assert property (mf_start_o |-> hist[dly + 7'(PROP_CYC) - 7'h1])
      else $error("multiframe start without boundary");
   a_lmfc_gives_mf: assert property (hist[dly + 7'(PROP_CYC) - 7'h1] |-> mf_start_o)
      else $error("boundary without multiframe start");
   a_ila_four_mf: assert property ($fell(ila_o) && data_o |-> icnt == 3'h4)
      else $error("alignment length wrong");
   a_ila_on_mf: assert property ($rose(ila_o) |-> $past(mf_start_o))
      else $error("alignment not on multiframe");
   a_data_after_ila: assert property ($rose(data_o) |-> $past(ila_o))
      else $error("data without alignment");
   a_one_lane_state: assert property ($onehot({cgs_o, ila_o, data_o}))
      else $error("lane state not one-hot");
   a_resync_pulse: assert property (resync_o |-> cgs_o ##1 !resync_o)
      else $error("resync pulse wrong");
   a_frame_at_lmfc: assert property (lmfc_o |-> frame_o)
      else $error("frame missing on boundary");
endmodule // jla_align_asserts

bind jla_align jla_align_asserts #(.PROP_CYC(PROP_CYC)) i_jla_align_asserts (
   .mclk_i, .rst_n_i, .sysref_i, .sync_n_i, .double_rate_i, .five_four_ratio_sel_i,
   .decim_i, .lmfc_o, .frame_o, .mf_start_o, .cgs_o, .ila_o, .data_o, .resync_o,
   .sync_aligned_o);

// >>> sim/jla_rx_model.sv
// Purpose: Receiver and SYSREF source facing the alignment block
// Assumes: Driven through its tasks, off the falling edge
// Notes:   Negative offset releases SYNC at once
`timescale 1ns/1ns
module jla_rx_model (
   input  wire logic mclk_i,
   input  wire logic frame_i,
   input  wire logic lmfc_i,
   output logic      sysref_o,
   output logic      sync_n_o
);
   // Idle levels
   initial begin
      sysref_o = 1'b0;
      sync_n_o = 1'b1;
   end

   // One SYSREF pulse with minimum high and low widths
   task automatic sref_pulse();
      @(negedge mclk_i) sysref_o = 1'b1;
      repeat (8) @(negedge mclk_i);
      sysref_o = 1'b0;
      repeat (8) @(negedge mclk_i);
   endtask

   // SYNC request held nfr frames, released ofs cycles past a boundary
   task automatic sync_req(input int nfr, input int ofs);
      @(negedge mclk_i) sync_n_o = 1'b0;
      repeat (nfr) @(posedge mclk_i iff frame_i);
      if (ofs >= 0) begin
         @(posedge mclk_i iff lmfc_i);
         repeat (ofs) @(posedge mclk_i);
      end
      @(negedge mclk_i) sync_n_o = 1'b1;
   endtask
endmodule // jla_rx_model

// >>> sim/test_jla_align.sv
// Purpose: Self-checking bench of the alignment block
// Assumes: K_FRAMES 32, F_OCTETS 1, no extra propagation
// Notes:   Event times are recorded on rising edges
`timescale 1ns/1ns
`include "jla_consts.svh"
module test_jla_align;
   logic       mclk_i;
   logic       rst_n_i;
   logic       dr;
   logic       p54;
   logic [5:0] dc;
   wire logic  sysref, sync_n, lmfc, frame, mf, cgs, ila, dat, rsy, sal;
   int         fails = 0, cmp_count = 0, cyc = 0;
   int         t_sr, t_lm, t_lp, t_mf, t_il, t_dt, nres = 0;
   int         c_fr = 0, n_fr = 0;
   logic [2:0] q = 3'h0;

   // Device clock
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   jla_align i_jla_align (.mclk_i, .rst_n_i, .sysref_i(sysref), .sync_n_i(sync_n),
      .double_rate_i(dr), .five_four_ratio_sel_i(p54), .decim_i(dc), .lmfc_o(lmfc),
      .frame_o(frame), .mf_start_o(mf), .cgs_o(cgs), .ila_o(ila), .data_o(dat),
      .resync_o(rsy), .sync_aligned_o(sal));
   jla_rx_model i_jla_rx_model (.mclk_i, .frame_i(frame), .lmfc_i(lmfc),
      .sysref_o(sysref), .sync_n_o(sync_n));

   // Event recorder and watchdog
   always @(posedge mclk_i) begin
      cyc++;
      if (sysref && !q[0]) t_sr = cyc;
      if (ila && !q[1]) t_il = cyc;
      if (dat && !q[2]) t_dt = cyc;
      q = {dat, ila, sysref};
      if (lmfc) begin
         t_lp = t_lm;
         t_lm = cyc;
         n_fr = c_fr;
         c_fr = 0;
      end
      if (frame) c_fr++;
      if (mf) t_mf = cyc;
      if (rsy) nres++;
      if (cyc > 10000) begin
         fails++;
         report_and_stop();
      end
   end

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("Checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   function automatic int up(input int t);
      return (t + `JLA_TENTHS_PER_CYC - 1) / `JLA_TENTHS_PER_CYC;
   endfunction

   // Reset with rate settings, checking the reset levels
   task automatic do_reset(input logic d, input logic p, input logic [5:0] c);
      @(negedge mclk_i);
      rst_n_i = 1'b0;
      dr = d;
      p54 = p;
      dc = c;
      repeat (6) @(negedge mclk_i);
      chk("cgs in reset", 16'h1, {15'h0, cgs});
      chk("outputs in reset", 16'h0, {9'h0, lmfc, frame, mf, ila, dat, rsy, sal});
      rst_n_i = 1'b1;
   endtask

   // SYSREF realign, boundary period and multiframe delay in one mode
   task automatic t_mode(input logic d, p, input logic [5:0] c, input int dl, ml);
      do_reset(d, p, c);
      i_jla_rx_model.sref_pulse();
      repeat (ml + 28) @(posedge mclk_i);
      // Registered boundary pulse is recorded one edge after the boundary itself
      chk("sysref to lmfc", 16'(`JLA_SREF_LMFC_CYC + 1), 16'(t_lp - t_sr));
      chk("frames per multiframe", 16'h20, 16'(n_fr));
      chk("lmfc period", 16'(ml), 16'(t_lm - t_lp));
      chk("lmfc to multiframe", 16'(dl), 16'(t_mf - t_lp));
      $display("mode test done");
   endtask

   // Link start with a four-frame request held to the next boundary, released early
   task automatic t_link(input int ml);
      do_reset(1'b1, 1'b0, 6'h01);
      i_jla_rx_model.sync_req(4, 10);
      repeat (8 * ml) @(posedge mclk_i);
      chk("ila length", 16'(4 * ml), 16'(t_dt - t_il));
      chk("data after ila", 16'h1, {15'h0, dat});
      chk("sync aligned", 16'h1, {15'h0, sal});
      $display("link test done");
   endtask

   // Too short a request leaves the link alone
   task automatic t_short(input int ml);
      int n;
      n = nres;
      i_jla_rx_model.sync_req(2, -1);
      repeat (2 * ml) @(posedge mclk_i);
      chk("short sync data", 16'h1, {15'h0, dat});
      chk("short sync resync", 16'(n), 16'(nres));
      $display("short test done");
   endtask

   // Resync whose release misses the setup window
   task automatic t_late(input int ml);
      int n;
      n = nres;
      i_jla_rx_model.sync_req(4, ml - 10);
      chk("resync count", 16'(n + 1), 16'(nres));
      chk("lanes during resync", 16'h4, {13'h0, cgs, ila, dat});
      repeat (8 * ml) @(posedge mclk_i);
      chk("late release data", 16'h1, {15'h0, dat});
      chk("late release flag", 16'h0, {15'h0, sal});
      $display("late test done");
   endtask

   // Main sequence
   initial begin
      rst_n_i = 1'b0;
      dr = 1'b1;
      p54 = 1'b0;
      dc = 6'h01;
      t_mode(1'b1, 1'b0, 6'h01, up(`JLA_DTX_BYP_TENTHS), 32 * `JLA_MULT_D1P0);
      t_mode(1'b0, 1'b0, 6'h08, up(`JLA_DTX_D0P0_TENTHS), 32 * `JLA_MULT_D0P0);
      t_mode(1'b0, 1'b1, 6'h08, up(`JLA_DTX_D0P1_TENTHS), 32 * `JLA_MULT_D0P1);
      t_mode(1'b1, 1'b0, 6'h04, up(`JLA_DTX_D1P0_TENTHS), 32 * `JLA_MULT_D1P0);
      t_mode(1'b1, 1'b1, 6'h10, up(`JLA_DTX_D1P1_TENTHS), 32 * `JLA_MULT_D1P1);
      t_link(32 * `JLA_MULT_D1P0);
      t_short(32 * `JLA_MULT_D1P0);
      t_late(32 * `JLA_MULT_D1P0);
      report_and_stop();
   end
endmodule // test_jla_align
